// ---- verilog/rtc_pkg.sv ----
// Constants, register map and carrier types for the receive transport check block.
// Assumes one 100 MHz clock shared by deframer, lane logic and the register bus.
package rtc_pkg;
	// ----------------------------------------
	// register indices; byte address is index * 4
	// ----------------------------------------
	localparam logic [11:0] RTC_IDX_TEST_CONTROL = 12'h32C;
	localparam logic [11:0] RTC_IDX_REF_LOW = 12'h32D;
	localparam logic [11:0] RTC_IDX_REF_HIGH = 12'h32E;
	localparam logic [11:0] RTC_IDX_RESULT = 12'h32F;
	localparam logic [11:0] RTC_IDX_LANE_INVERT = 12'h334;
	localparam logic [11:0] RTC_IDX_DEVICE_NUMBER = 12'h400;
	localparam logic [11:0] RTC_IDX_ADJUST_BANK = 12'h401;
	localparam logic [11:0] RTC_IDX_LANE0_FLAGS = 12'h402;
	localparam logic [11:0] RTC_IDX_IRQ_STATUS = 12'h410;
	localparam logic [11:0] RTC_IDX_IRQ_MASK = 12'h411;
	localparam int RTC_ADDR_W = 14;
	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int RTC_CTL_ENABLE = 0;
	localparam int RTC_CTL_CLEAR = 1;
	localparam int RTC_CTL_CONV_LSB = 2;
	localparam int RTC_CTL_SAMPLE_LSB = 4;
	localparam logic [7:0] RTC_RESET_BYTE = 8'h00;
	localparam logic [7:0] RTC_CTL_WRITABLE = 8'h3F;
	localparam logic [7:0] RTC_INVERT_WRITABLE = 8'h0F;
	localparam logic [7:0] RTC_FLAGS_WRITABLE = 8'h7F;
	localparam int RTC_IRQ_FAIL = 0;
	localparam int RTC_IRQ_CAPTURE = 1;
	localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
	localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic [3:0][3:0][15:0] sample;
	} rtc_frame_t;
	typedef struct packed {
		logic valid;
		logic [3:0][7:0] data;
	} rtc_lanes_t;
	typedef struct packed {
		logic valid;
		logic [7:0] device_number;
		logic [7:0] adjust_bank;
		logic [7:0] lane_flags;
	} rtc_lane_cfg_t;
endpackage

// ---- verilog/rtc_transport_check.sv ----
// Transport check, lane polarity inversion and lane 0 link parameter capture,
// with an AXI4-Lite register slave and one level interrupt.
// Assumes deframer, lane and alignment inputs arrive on ref_clk.
//
// How it works
// (RQ1) converter select picks compared sample stream
// (RQ2) sample select picks compared sample position
// (RQ3) clear bit resets result; zero leaves it
// (RQ4) comparison runs only while enable is set
// (RQ5) low reference byte is read-write register
// (RQ6) high reference byte is read-write register
// (RQ7) compare reference against deframed selected sample
// (RQ8) fail bit reports match pass, mismatch fail
// (RQ9) fail sticks until cleared; zero while matching
// (RQ10) invert lane x data when mask bit set
// (RQ11) capture lane 0 device number, read-only
// (RQ12) capture adjust resolution into upper nibble
// (RQ13) capture bank number into lower nibble
// (RQ14) transmitter sends adjust direction zero; shown
// (RQ15) transmitter sends phase request zero; shown
// (RQ16) capture lane 0 lane number, low bits
// (RQ17) recapture each alignment; zero before first
//
// Local design decision: the AXI4-Lite interface to the registers.
module rtc_transport_check
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// axi4-lite write
	input wire logic [RTC_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [RTC_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// receive data path
	input wire rtc_frame_t frame_in,
	input wire rtc_lanes_t lanes_in,
	output rtc_lanes_t lanes_out,
	input wire rtc_lane_cfg_t lane0_cfg,
	// interrupt
	output logic irq
);
	function automatic logic [11:0] reg_index(input logic [RTC_ADDR_W-1:0] addr);
		reg_index = addr[RTC_ADDR_W-1:2];
	endfunction

	function automatic logic is_mapped(input logic [11:0] idx);
		case (idx)
			RTC_IDX_TEST_CONTROL, RTC_IDX_REF_LOW, RTC_IDX_REF_HIGH, RTC_IDX_RESULT,
			RTC_IDX_LANE_INVERT, RTC_IDX_DEVICE_NUMBER, RTC_IDX_ADJUST_BANK,
			RTC_IDX_LANE0_FLAGS, RTC_IDX_IRQ_STATUS, RTC_IDX_IRQ_MASK: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	logic [7:0] test_control;
	logic [7:0] ref_low;
	logic [7:0] ref_high;
	logic [7:0] lane_invert;
	logic [7:0] irq_mask;
	logic [7:0] irq_status;
	logic [7:0] device_number;
	logic [7:0] adjust_bank;
	logic [7:0] lane_flags;
	logic fail;
	logic aw_held;
	logic w_held;
	logic [11:0] aw_idx;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic next_aw_held;
	logic next_w_held;
	logic next_rvalid;
	logic wr_fire;
	logic ar_fire;
	logic status_read;
	logic [31:0] rd_word;
	logic [15:0] picked;
	logic mismatch;
	logic fail_event;
	logic [7:0] events;

	// ----------------------------------------
	// bus write channel
	// ----------------------------------------
	// address and data may land in either order; response once both are held
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
		end else if (wr_fire) begin
			next_aw_held = 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
		end else if (wr_fire) begin
			next_w_held = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			aw_idx <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			s_axi_awready <= !next_aw_held;
			s_axi_wready <= !next_w_held;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx <= reg_index(s_axi_awaddr);
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RTC_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= is_mapped(aw_idx) ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// writable registers
	// ----------------------------------------
	// only byte lane 0 carries data; other lanes are ignored
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			test_control <= RTC_RESET_BYTE;
			ref_low <= RTC_RESET_BYTE;
			ref_high <= RTC_RESET_BYTE;
			lane_invert <= RTC_RESET_BYTE;
			irq_mask <= RTC_RESET_BYTE;
		end else if (wr_fire && w_strb[0]) begin
			case (aw_idx)
				RTC_IDX_TEST_CONTROL: test_control <= w_data[7:0] & RTC_CTL_WRITABLE;
				RTC_IDX_REF_LOW: ref_low <= w_data[7:0]; // RQ5
				RTC_IDX_REF_HIGH: ref_high <= w_data[7:0]; // RQ6
				RTC_IDX_LANE_INVERT: lane_invert <= w_data[7:0] & RTC_INVERT_WRITABLE;
				RTC_IDX_IRQ_MASK: irq_mask <= w_data[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------
	// bus read channel
	// ----------------------------------------
	assign ar_fire = s_axi_arvalid && s_axi_arready;
	assign status_read = ar_fire && (reg_index(s_axi_araddr) == RTC_IDX_IRQ_STATUS);

	always_comb begin
		rd_word = 32'h00000000;
		case (reg_index(s_axi_araddr))
			RTC_IDX_TEST_CONTROL: rd_word[7:0] = test_control;
			RTC_IDX_REF_LOW: rd_word[7:0] = ref_low;
			RTC_IDX_REF_HIGH: rd_word[7:0] = ref_high;
			RTC_IDX_RESULT: rd_word[0] = fail; // RQ8
			RTC_IDX_LANE_INVERT: rd_word[7:0] = lane_invert;
			RTC_IDX_DEVICE_NUMBER: rd_word[7:0] = device_number; // RQ11
			RTC_IDX_ADJUST_BANK: rd_word[7:0] = adjust_bank; // RQ12 RQ13
			RTC_IDX_LANE0_FLAGS: rd_word[7:0] = lane_flags; // RQ14 RQ15 RQ16
			RTC_IDX_IRQ_STATUS: rd_word[7:0] = irq_status;
			RTC_IDX_IRQ_MASK: rd_word[7:0] = irq_mask;
			default: rd_word = 32'h00000000;
		endcase
	end

	always_comb begin
		next_rvalid = s_axi_rvalid;
		if (ar_fire) begin
			next_rvalid = 1'b1;
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RTC_RESP_OKAY;
		end else begin
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (ar_fire) begin
				s_axi_rdata <= rd_word;
				s_axi_rresp <= is_mapped(reg_index(s_axi_araddr)) ? RTC_RESP_OKAY
					: RTC_RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------
	// transport check
	// ----------------------------------------
	assign picked = frame_in.sample[test_control[RTC_CTL_CONV_LSB +: 2]] // RQ1
		[test_control[RTC_CTL_SAMPLE_LSB +: 2]]; // RQ2
	assign mismatch = frame_in.valid && (picked != {ref_high, ref_low}); // RQ7
	assign fail_event = test_control[RTC_CTL_ENABLE] && !test_control[RTC_CTL_CLEAR]
		&& mismatch && !fail; // RQ4

	// clear is a level: while it is held the result stays at pass
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			fail <= 1'b0;
		end else if (test_control[RTC_CTL_CLEAR]) begin
			fail <= 1'b0; // RQ3
		end else if (test_control[RTC_CTL_ENABLE] && mismatch) begin
			fail <= 1'b1; // RQ9
		end
	end

	// ----------------------------------------
	// lane polarity
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lanes_out <= '0;
		end else begin
			lanes_out.valid <= lanes_in.valid;
			for (int i = 0; i < 4; i++) begin
				lanes_out.data[i] <= lanes_in.data[i] ^ {8{lane_invert[i]}}; // RQ10
			end
		end
	end

	// ----------------------------------------
	// lane 0 configuration capture
	// ----------------------------------------
	// fields are shown as received; the transmitter is trusted to send zero
	// in the adjust direction and phase request bits
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			device_number <= RTC_RESET_BYTE;
			adjust_bank <= RTC_RESET_BYTE;
			lane_flags <= RTC_RESET_BYTE;
		end else if (lane0_cfg.valid) begin
			device_number <= lane0_cfg.device_number; // RQ11 RQ17
			adjust_bank <= lane0_cfg.adjust_bank; // RQ12 RQ13
			lane_flags <= lane0_cfg.lane_flags & RTC_FLAGS_WRITABLE; // RQ14 RQ15 RQ16
		end
	end

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	always_comb begin
		events = 8'h00;
		events[RTC_IRQ_FAIL] = fail_event;
		events[RTC_IRQ_CAPTURE] = lane0_cfg.valid;
	end

	// an event in the cycle of a status read survives the clear
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_status <= RTC_RESET_BYTE;
		end else begin
			irq_status <= (status_read ? 8'h00 : irq_status) | events;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_aw_taken;
		s_axi_awvalid && s_axi_awready;
	endsequence

	sequence s_w_taken;
		s_axi_wvalid && s_axi_wready;
	endsequence

	a_fail_on_mismatch: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
		(test_control[0] && !test_control[1] && frame_in.valid
		&& frame_in.sample[test_control[3:2]][test_control[5:4]] != {ref_high, ref_low})
		|=> fail ##1 (fail || $past(test_control[1])))
		else $error("fail not raised on mismatch");

	a_fail_sticky: assert property (@(posedge ref_clk) disable iff (rst) // RQ9
		fail && !test_control[1] |=> fail)
		else $error("fail dropped without clear");

	a_clear_result: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
		test_control[1] |=> !fail)
		else $error("clear did not reset result");

	a_disabled_idle: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
		!test_control[0] && !fail |=> !fail)
		else $error("fail set while disabled");

	a_match_passes: assert property (@(posedge ref_clk) disable iff (rst) // RQ7
		!fail && (!frame_in.valid
		|| frame_in.sample[test_control[3:2]][test_control[5:4]] == {ref_high, ref_low})
		|=> !fail)
		else $error("fail set on matching sample");

	a_lane_invert: assert property (@(posedge ref_clk) disable iff (rst) // RQ10
		lanes_in.valid |=> lanes_out.valid && lanes_out.data[0]
		== ($past(lanes_in.data[0]) ^ {8{$past(lane_invert[0])}})
		&& lanes_out.data[3] == ($past(lanes_in.data[3]) ^ {8{$past(lane_invert[3])}}))
		else $error("lane polarity wrong");

	a_cfg_capture: assert property (@(posedge ref_clk) disable iff (rst) // RQ17
		lane0_cfg.valid |=> device_number == $past(lane0_cfg.device_number)
		&& adjust_bank == $past(lane0_cfg.adjust_bank)
		&& lane_flags[4:0] == $past(lane0_cfg.lane_flags[4:0]))
		else $error("lane 0 parameters not captured");

	a_cfg_steady: assert property (@(posedge ref_clk) disable iff (rst) // RQ11
		!lane0_cfg.valid |=> $stable(device_number) && $stable(adjust_bank))
		else $error("parameters changed without alignment");

	a_write_answer: assert property (@(posedge ref_clk) disable iff (rst)
		(s_aw_taken and s_w_taken) ##0 !s_axi_bvalid |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");

	a_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data missing");

	a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
		|(irq_status & irq_mask) |=> irq)
		else $error("interrupt not raised");

endmodule // rtc_transport_check

// ---- dv/rtc_tx_model.sv ----
// Link transmitter model: deframed samples, lane octets, lane 0 config beats.
// Assumes the bench calls its tasks from one process, timed on ref_clk.
module rtc_tx_model
	import rtc_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// link side
	output rtc_frame_t frame_in,
	output rtc_lanes_t lanes_in,
	output rtc_lane_cfg_t lane0_cfg
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		frame_in = '0;
		lanes_in = '0;
		lane0_cfg = '0;
	end
	// payload is inverted after each beat so a held stale value is never trusted
	task automatic send_frame(input logic [15:0] sel, oth, input logic [1:0] c, p);
		logic [3:0][3:0][15:0] s;
		s = {16{oth}};
		s[c][p] = sel;
		@(posedge ref_clk);
		frame_in <= {1'b1, s};
		@(posedge ref_clk);
		frame_in <= {1'b0, ~s};
	endtask
	task automatic send_lanes(input logic [31:0] d);
		@(posedge ref_clk);
		lanes_in <= {1'b1, d};
		@(posedge ref_clk);
		lanes_in <= {1'b0, ~d};
	endtask
	task automatic send_cfg(input logic [7:0] dev, adj, input logic [4:0] lane);
		@(posedge ref_clk);
		lane0_cfg <= {1'b1, dev, adj, 3'h0, lane};
		@(posedge ref_clk);
		lane0_cfg <= {1'b0, ~dev, ~adj, 3'h7, ~lane};
	endtask
endmodule // rtc_tx_model

// ---- dv/rtc_transport_check_tb.sv ----
// Bench: AXI4-Lite register tasks, transport check, lane invert, lane 0 capture.
// Assumes rtc_tx_model drives the link side on the same clock.
module rtc_transport_check_tb import rtc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = '0;
	logic rst = '1;
	logic [RTC_ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp, cc, pp;
	rtc_frame_t frame_in;
	rtc_lanes_t lanes_in, lanes_out;
	rtc_lane_cfg_t lane0_cfg;
	int error_cnt = 0;
	int samples_checked = 0;
	rtc_transport_check u_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .frame_in(frame_in), .lanes_in(lanes_in),
		.lanes_out(lanes_out), .lane0_cfg(lane0_cfg), .irq(irq));
	rtc_tx_model u_tx (.ref_clk(ref_clk), .frame_in(frame_in), .lanes_in(lanes_in),
		.lane0_cfg(lane0_cfg));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic hang();
		error_cnt++;
		$display("unexpected handshake expected answer seen timeout");
		complete_run();
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d,
		input logic [1:0] er = RTC_RESP_OKAY);
		int i;
		@(posedge ref_clk);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		if (i == 50) hang();
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] idx, input logic [7:0] exp,
		input logic [1:0] er = RTC_RESP_OKAY);
		int i;
		@(posedge ref_clk);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		if (i == 50) hang();
		chk("rdata", rdata, {24'h0, exp});
		chk("rresp", {30'h0, rresp}, {30'h0, er});
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		logic [11:0] regs [10];
		regs = '{RTC_IDX_TEST_CONTROL, RTC_IDX_REF_LOW, RTC_IDX_REF_HIGH, RTC_IDX_RESULT,
			RTC_IDX_LANE_INVERT, RTC_IDX_DEVICE_NUMBER, RTC_IDX_ADJUST_BANK,
			RTC_IDX_LANE0_FLAGS, RTC_IDX_IRQ_STATUS, RTC_IDX_IRQ_MASK};
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		foreach (regs[k]) rd(regs[k], 8'h00);
		rd(12'h3FF, 8'h00, RTC_RESP_SLVERR);
		wr(12'h3FF, 8'hFF, RTC_RESP_SLVERR);
		$display("test reset values done");
		wr(RTC_IDX_REF_LOW, 8'hA5);
		wr(RTC_IDX_REF_HIGH, 8'h3C);
		wr(RTC_IDX_RESULT, 8'hFF);
		wr(RTC_IDX_DEVICE_NUMBER, 8'hFF);
		wr(RTC_IDX_LANE_INVERT, 8'hFF);
		rd(RTC_IDX_REF_LOW, 8'hA5);
		rd(RTC_IDX_REF_HIGH, 8'h3C);
		rd(RTC_IDX_RESULT, 8'h00);
		rd(RTC_IDX_DEVICE_NUMBER, 8'h00);
		rd(RTC_IDX_LANE_INVERT, 8'h0F);
		// byte lane 0 strobe low: accepted but nothing stored
		wstrb <= 4'hE;
		wr(RTC_IDX_REF_LOW, 8'h00);
		wstrb <= 4'hF;
		rd(RTC_IDX_REF_LOW, 8'hA5);
		wr(RTC_IDX_IRQ_MASK, 8'h01);
		$display("test register access done");
		// other samples carry the opposite value, so a wrong select shows up
		for (int n = 0; n < 4; n++) begin
			cc = 2'(n);
			pp = ~cc;
			wr(RTC_IDX_TEST_CONTROL, {2'h0, pp, cc, 2'h1});
			u_tx.send_frame(16'h3CA5, 16'hC35A, cc, pp);
			rd(RTC_IDX_RESULT, 8'h00);
			u_tx.send_frame(16'hC35A, 16'h3CA5, cc, pp);
			rd(RTC_IDX_RESULT, 8'h01);
			chk("irq", {31'h0, irq}, 32'h1);
			rd(RTC_IDX_IRQ_STATUS, 8'h01);
			wr(RTC_IDX_TEST_CONTROL, {2'h0, pp, cc, 2'h0});
			rd(RTC_IDX_RESULT, 8'h01);
			wr(RTC_IDX_TEST_CONTROL, 8'h02);
			rd(RTC_IDX_RESULT, 8'h00);
			chk("irq", {31'h0, irq}, 32'h0);
		end
		wr(RTC_IDX_TEST_CONTROL, 8'h00);
		u_tx.send_frame(16'hC35A, 16'hC35A, 2'h0, 2'h0);
		rd(RTC_IDX_RESULT, 8'h00);
		$display("test transport check done");
		wr(RTC_IDX_LANE_INVERT, 8'h05);
		u_tx.send_lanes(32'h11223344);
		@(negedge ref_clk);
		chk("lanes", lanes_out.data, 32'h11DD33BB);
		chk("lanes_valid", {31'h0, lanes_out.valid}, 32'h1);
		$display("test lane invert done");
		u_tx.send_cfg(8'h9A, 8'h7E, 5'h13);
		rd(RTC_IDX_DEVICE_NUMBER, 8'h9A);
		rd(RTC_IDX_ADJUST_BANK, 8'h7E);
		rd(RTC_IDX_LANE0_FLAGS, 8'h13);
		chk("irq", {31'h0, irq}, 32'h0);
		rd(RTC_IDX_IRQ_STATUS, 8'h02);
		u_tx.send_cfg(8'h21, 8'hB4, 5'h0C);
		rd(RTC_IDX_DEVICE_NUMBER, 8'h21);
		rd(RTC_IDX_ADJUST_BANK, 8'hB4);
		rd(RTC_IDX_LANE0_FLAGS, 8'h0C);
		wr(RTC_IDX_IRQ_MASK, 8'h02);
		rd(RTC_IDX_IRQ_MASK, 8'h02);
		chk("irq", {31'h0, irq}, 32'h1);
		$display("test lane 0 capture done");
		complete_run();
	end
endmodule // rtc_transport_check_tb
